// file: rtl/sgs_regs.sv
// module: sensor gain select register bank on the special function register bus
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - channel-one gain register, 8-bit read/write at 0xA1, cleared on reset
// - channel-one bits 4:0 pick second-stage gain, 1.00 to 25.06 V/V
// - channel-one bits 7:5 pick first-stage gain, codes 000..101, 3.00 to 25.50
// - channel-two gain register, 8-bit read/write at 0xA2, cleared on reset
// - channel-two bits 4:0 pick second-stage gain with the same table
// - channel-two bits 7:5 pick first-stage gain with the same table
module sgs_regs (
  // clock, reset, enable
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_ce,
  // special function register bus
  input  wire logic [7:0]                i_sfr_addr,
  input  wire logic                      i_sfr_wr,
  input  wire logic                      i_sfr_rd,
  input  wire logic [7:0]                i_sfr_wdata,
  output logic      [7:0]                o_sfr_rdata,
  output logic                           o_sfr_rd_hit,
  // channel one front-end gain
  output logic      [sgs_pkg::SGS_STG1_W-1:0] o_channel_one_first_stage_gain,
  output logic      [sgs_pkg::SGS_STG2_W-1:0] o_channel_one_second_stage_gain,
  output sgs_pkg::sgs_gain_t             o_channel_one_first_stage_x100,
  output sgs_pkg::sgs_gain_t             o_channel_one_second_stage_x100,
  output logic                           o_channel_one_first_stage_rsvd,
  // channel two front-end gain
  output logic      [sgs_pkg::SGS_STG1_W-1:0] o_channel_two_first_stage_gain,
  output logic      [sgs_pkg::SGS_STG2_W-1:0] o_channel_two_second_stage_gain,
  output sgs_pkg::sgs_gain_t             o_channel_two_first_stage_x100,
  output sgs_pkg::sgs_gain_t             o_channel_two_second_stage_x100,
  output logic                           o_channel_two_first_stage_rsvd
);
  import sgs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  // runs regardless of i_ce so reset always completes
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_sync_n);

  ////////////////////////////////////////////////////////////////////////////
  // gain registers

  logic [SGS_REG_W-1:0] ch_reg_q [SGS_NUM_CH];
  logic [SGS_REG_W-1:0] ch_reg_d [SGS_NUM_CH];
  logic [7:0]           ch_addr  [SGS_NUM_CH];

  assign ch_addr[0] = SGS_ADDR_CH1;
  assign ch_addr[1] = SGS_ADDR_CH2;

  // per channel: write decode, storage, decoder, registered outputs
  logic [SGS_STG1_W-1:0] stg1_q    [SGS_NUM_CH];
  logic [SGS_STG1_W-1:0] stg1_d    [SGS_NUM_CH];
  logic [SGS_STG2_W-1:0] stg2_q    [SGS_NUM_CH];
  logic [SGS_STG2_W-1:0] stg2_d    [SGS_NUM_CH];
  sgs_gain_t             stg1_x_q  [SGS_NUM_CH];
  sgs_gain_t             stg1_x_d  [SGS_NUM_CH];
  sgs_gain_t             stg2_x_q  [SGS_NUM_CH];
  sgs_gain_t             stg2_x_d  [SGS_NUM_CH];
  logic                  rsvd_q    [SGS_NUM_CH];
  logic                  rsvd_d    [SGS_NUM_CH];

  for (genvar c = 0; c < SGS_NUM_CH; c++) begin : g_ch
    sgs_gain_if gif ();

    // all eight bits stored as written, reserved codes included
    always_comb begin
      ch_reg_d[c] = ch_reg_q[c];
      if (i_ce && i_sfr_wr && (i_sfr_addr == ch_addr[c])) begin
        ch_reg_d[c] = i_sfr_wdata;
      end
    end

    always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        ch_reg_q[c] <= SGS_REG_RESET;
      end else begin
        ch_reg_q[c] <= ch_reg_d[c];
      end
    end

    assign gif.reg_val = ch_reg_q[c];

    sgs_gain_decode u_dec (
      .gif (gif.dec)
    );

    always_comb begin
      stg1_d[c]   = stg1_q[c];
      stg2_d[c]   = stg2_q[c];
      stg1_x_d[c] = stg1_x_q[c];
      stg2_x_d[c] = stg2_x_q[c];
      rsvd_d[c]   = rsvd_q[c];
      if (i_ce) begin
        stg1_d[c]   = gif.stg1_code;
        stg2_d[c]   = gif.stg2_code;
        stg1_x_d[c] = gif.stg1_x100;
        stg2_x_d[c] = gif.stg2_x100;
        rsvd_d[c]   = gif.stg1_rsvd;
      end
    end

    always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        stg1_q[c]   <= SGS_STG1_SAFE_CODE;
        stg2_q[c]   <= SGS_REG_RESET[SGS_STG2_MSB:SGS_STG2_LSB];
        stg1_x_q[c] <= SGS_STG1_X100[0];
        stg2_x_q[c] <= SGS_STG2_X100[0];
        rsvd_q[c]   <= 1'b0;
      end else begin
        stg1_q[c]   <= stg1_d[c];
        stg2_q[c]   <= stg2_d[c];
        stg1_x_q[c] <= stg1_x_d[c];
        stg2_x_q[c] <= stg2_x_d[c];
        rsvd_q[c]   <= rsvd_d[c];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  // unmapped reads return zero with hit low, so the core can or the bus
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rd_hit_q;
  logic       rd_hit_d;

  always_comb begin
    rdata_d  = rdata_q;
    rd_hit_d = rd_hit_q;
    if (i_ce) begin
      rdata_d  = SGS_RDATA_UNMAPPED;
      rd_hit_d = 1'b0;
      if (i_sfr_rd && (i_sfr_addr == SGS_ADDR_CH1)) begin
        rdata_d  = ch_reg_q[0];
        rd_hit_d = 1'b1;
      end else if (i_sfr_rd && (i_sfr_addr == SGS_ADDR_CH2)) begin
        rdata_d  = ch_reg_q[1];
        rd_hit_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_q  <= SGS_RDATA_UNMAPPED;
      rd_hit_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rd_hit_q <= rd_hit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_sfr_rdata                     = rdata_q;
  assign o_sfr_rd_hit                    = rd_hit_q;
  assign o_channel_one_first_stage_gain  = stg1_q[0];
  assign o_channel_one_second_stage_gain = stg2_q[0];
  assign o_channel_one_first_stage_x100  = stg1_x_q[0];
  assign o_channel_one_second_stage_x100 = stg2_x_q[0];
  assign o_channel_one_first_stage_rsvd  = rsvd_q[0];
  assign o_channel_two_first_stage_gain  = stg1_q[1];
  assign o_channel_two_second_stage_gain = stg2_q[1];
  assign o_channel_two_first_stage_x100  = stg1_x_q[1];
  assign o_channel_two_second_stage_x100 = stg2_x_q[1];
  assign o_channel_two_first_stage_rsvd  = rsvd_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_wr_ch1;
    i_ce && i_sfr_wr && (i_sfr_addr == SGS_ADDR_CH1);
  endsequence

  sequence s_wr_ch2;
    i_ce && i_sfr_wr && (i_sfr_addr == SGS_ADDR_CH2);
  endsequence

  sequence s_rd_ch1;
    i_ce && i_sfr_rd && (i_sfr_addr == SGS_ADDR_CH1);
  endsequence

  property p_ch1_wr_rd;
    logic [7:0] v;
    (s_wr_ch1, v = i_sfr_wdata) ##1 (s_rd_ch1 and !i_sfr_wr)
      |=> o_sfr_rd_hit && (o_sfr_rdata == v);
  endproperty
  a_ch1_wr_rd: assert property (p_ch1_wr_rd) else $error("ch1 readback wrong");

  // output lags the register by one enabled edge, so compare against the value a cycle back
  property p_ch2_wr;
    s_wr_ch2 |=> (ch_reg_q[1] == $past(i_sfr_wdata)) ##1
      (!$past(i_ce) || o_channel_two_second_stage_gain
                       == $past(ch_reg_q[1][SGS_STG2_MSB:SGS_STG2_LSB]));
  endproperty
  a_ch2_wr: assert property (p_ch2_wr) else $error("ch2 write not taken");

  property p_ch1_stg2;
    i_ce |=> (o_channel_one_second_stage_x100
              == SGS_STG2_X100[$past(ch_reg_q[0][SGS_STG2_MSB:SGS_STG2_LSB])]);
  endproperty
  a_ch1_stg2: assert property (p_ch1_stg2) else $error("ch1 stage2 gain wrong");

  property p_ch1_stg1;
    i_ce && (ch_reg_q[0][SGS_STG1_MSB:SGS_STG1_LSB] <= SGS_STG1_MAX_CODE)
      |=> (o_channel_one_first_stage_gain == $past(ch_reg_q[0][SGS_STG1_MSB:SGS_STG1_LSB]))
          && !o_channel_one_first_stage_rsvd;
  endproperty
  a_ch1_stg1: assert property (p_ch1_stg1) else $error("ch1 stage1 gain wrong");

  property p_ch2_stg2;
    i_ce |=> (o_channel_two_second_stage_gain
              == $past(ch_reg_q[1][SGS_STG2_MSB:SGS_STG2_LSB]));
  endproperty
  a_ch2_stg2: assert property (p_ch2_stg2) else $error("ch2 stage2 gain wrong");

  property p_ch2_stg1;
    i_ce && (ch_reg_q[1][SGS_STG1_MSB:SGS_STG1_LSB] <= SGS_STG1_MAX_CODE)
      |=> (o_channel_two_first_stage_x100
           == SGS_STG1_X100[$past(ch_reg_q[1][SGS_STG1_MSB:SGS_STG1_LSB])]);
  endproperty
  a_ch2_stg1: assert property (p_ch2_stg1) else $error("ch2 stage1 gain wrong");

  property p_rsvd;
    s_wr_ch1 ##0 (i_sfr_wdata[SGS_STG1_MSB:SGS_STG1_LSB] > SGS_STG1_MAX_CODE)
      ##1 i_ce
      |=> o_channel_one_first_stage_rsvd
          && (o_channel_one_first_stage_gain == SGS_STG1_SAFE_CODE)
          && (ch_reg_q[0] == $past(ch_reg_q[0]) || $past(i_sfr_wr));
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code not handled");

  property p_freeze;
    !i_ce |=> $stable(ch_reg_q[0]) && $stable(ch_reg_q[1]) && $stable(o_sfr_rdata);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

endmodule // sgs_regs

`default_nettype wire

// file: shared/sgs_pkg.sv
// package: addresses, field layout and gain tables of the sensor gain select registers
package sgs_pkg;

  // extended_function_reg_space addresses
  localparam logic [7:0] SGS_ADDR_CH1      = 8'hA1;
  localparam logic [7:0] SGS_ADDR_CH2      = 8'hA2;

  // register layout
  localparam int         SGS_REG_W         = 8;
  localparam logic [7:0] SGS_REG_RESET     = 8'h00;
  localparam logic [7:0] SGS_RDATA_UNMAPPED = 8'h00;
  localparam int         SGS_STG1_MSB      = 7;
  localparam int         SGS_STG1_LSB      = 5;
  localparam int         SGS_STG2_MSB      = 4;
  localparam int         SGS_STG2_LSB      = 0;
  localparam int         SGS_STG1_W        = 3;
  localparam int         SGS_STG2_W        = 5;
  localparam int         SGS_NUM_CH        = 2;

  // first-stage codes above this one are reserved
  localparam logic [2:0] SGS_STG1_MAX_CODE = 3'h5;
  // code driven to the front end in place of a reserved one
  localparam logic [2:0] SGS_STG1_SAFE_CODE = 3'h0;

  // gains in hundredths of V/V
  localparam int         SGS_GAIN_W        = 12;
  typedef logic [SGS_GAIN_W-1:0] sgs_gain_t;

  localparam sgs_gain_t SGS_STG2_X100 [32] = '{
    12'h064, 12'h06E, 12'h07A, 12'h087, 12'h096, 12'h0A7, 12'h0B9, 12'h0CD,
    12'h0E4, 12'h0FD, 12'h119, 12'h137, 12'h15A, 12'h182, 12'h1AA, 12'h1DC,
    12'h20E, 12'h24A, 12'h286, 12'h2CC, 12'h31C, 12'h376, 12'h3DA, 12'h448,
    12'h4C0, 12'h542, 12'h5D8, 12'h678, 12'h72C, 12'h7FE, 12'h8D0, 12'h9CA
  };

  localparam sgs_gain_t SGS_STG1_X100 [8] = '{
    12'h12C, 12'h1BB, 12'h2A8, 12'h3FC, 12'h5B1, 12'h9F6, 12'h12C, 12'h12C
  };

endpackage

// file: shared/sgs_gain_if.sv
// interface: one channel's register value and its decoded gain selection
`timescale 1ns/100ps
`default_nettype none

interface sgs_gain_if;
  import sgs_pkg::*;

  logic [SGS_REG_W-1:0]  reg_val;
  logic [SGS_STG1_W-1:0] stg1_code;
  logic [SGS_STG2_W-1:0] stg2_code;
  sgs_gain_t             stg1_x100;
  sgs_gain_t             stg2_x100;
  logic                  stg1_rsvd;

  modport regs (
    output reg_val,
    input  stg1_code,
    input  stg2_code,
    input  stg1_x100,
    input  stg2_x100,
    input  stg1_rsvd
  );

  modport dec (
    input  reg_val,
    output stg1_code,
    output stg2_code,
    output stg1_x100,
    output stg2_x100,
    output stg1_rsvd
  );

endinterface

`default_nettype wire

// file: rtl/sgs_gain_decode.sv
// module: decodes one gain register into front-end gain selections
`timescale 1ns/100ps
`default_nettype none

module sgs_gain_decode (
  sgs_gain_if.dec gif
);
  import sgs_pkg::*;

  logic [SGS_STG1_W-1:0] raw_stg1;

  always_comb begin
    raw_stg1      = gif.reg_val[SGS_STG1_MSB:SGS_STG1_LSB];
    gif.stg2_code = gif.reg_val[SGS_STG2_MSB:SGS_STG2_LSB];
    gif.stg2_x100 = SGS_STG2_X100[gif.stg2_code];
    // reserved codes fall back to the lowest gain so the front end cannot saturate
    gif.stg1_rsvd = (raw_stg1 > SGS_STG1_MAX_CODE);
    gif.stg1_code = gif.stg1_rsvd ? SGS_STG1_SAFE_CODE : raw_stg1;
    gif.stg1_x100 = SGS_STG1_X100[gif.stg1_code];
  end

endmodule // sgs_gain_decode

`default_nettype wire

// file: dv/sgs_core_model.sv
// partner model: core side of the special function register bus
`timescale 1ns/100ps
`default_nettype none

module sgs_core_model (
  // bus toward the register bank
  input  wire logic       i_clk,
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_hit
);
  initial begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // idle lines flip so a stale address or data can never pass for a request
  task automatic idle();
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = ~o_addr;
    o_wdata = ~o_wdata;
  endtask

  // reserved first-stage codes are only sent when the bench asks for them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = d;
    o_wr    = 1'b1;
    @(negedge i_clk);
    idle();
  endtask

  // write then read back on the very next edge, as the core may do
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] wd, output logic [7:0] d,
                       output logic h);
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = wd;
    o_wr    = 1'b1;
    @(negedge i_clk);
    o_wr    = 1'b0;
    o_rd    = 1'b1;
    @(negedge i_clk);
    d = i_rdata;
    h = i_hit;
    idle();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge i_clk);
    o_addr = a;
    o_rd   = 1'b1;
    @(negedge i_clk);
    d = i_rdata;
    h = i_hit;
    idle();
  endtask
endmodule // sgs_core_model

`default_nettype wire

// file: dv/sensor_gain_select_regs_bench.sv
// testbench: gain select register bank against a behavioural model
`timescale 1ns/100ps
`default_nettype none

module sensor_gain_select_regs_bench;
  import sgs_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst_n;
  logic       ce;
  logic [7:0] addr, wdata, rdata;
  logic       wr, rd, hit;
  logic [2:0] g1 [2];
  logic [4:0] g2 [2];
  sgs_gain_t  x1 [2];
  sgs_gain_t  x2 [2];
  logic       rv [2];
  logic [7:0] reg_m [2];
  logic [31:0] seed = 32'h4EF33A20;
  int mismatches = 0;
  int checks_done = 0;
  int s1 [8] = '{300, 443, 680, 1020, 1457, 2550, 300, 300};
  int s2 [32] = '{100, 110, 122, 135, 150, 167, 185, 205, 228, 253, 281, 311, 346, 386,
    426, 476, 526, 586, 646, 716, 796, 886, 986, 1096, 1216, 1346, 1496, 1656, 1836,
    2046, 2256, 2506};

  always #5 clk_sys = ~clk_sys;

  sgs_core_model core (.i_clk(clk_sys), .o_addr(addr), .o_wr(wr), .o_rd(rd),
    .o_wdata(wdata), .i_rdata(rdata), .i_hit(hit));

  sgs_regs dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_ce(ce), .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .o_sfr_rd_hit(hit),
    .o_channel_one_first_stage_gain(g1[0]), .o_channel_one_second_stage_gain(g2[0]),
    .o_channel_one_first_stage_x100(x1[0]), .o_channel_one_second_stage_x100(x2[0]),
    .o_channel_one_first_stage_rsvd(rv[0]),
    .o_channel_two_first_stage_gain(g1[1]), .o_channel_two_second_stage_gain(g2[1]),
    .o_channel_two_first_stage_x100(x1[1]), .o_channel_two_second_stage_x100(x2[1]),
    .o_channel_two_first_stage_rsvd(rv[1]));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic conclude();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reserved first-stage codes fall back to the lowest gain with a flag
  task automatic chk_gain(input int ch);
    logic [2:0] c;
    c = reg_m[ch][7:5];
    chk(g1[ch], (c > 3'h5) ? 3'h0 : c);
    chk(rv[ch], c > 3'h5);
    chk(x1[ch], s1[c]);
    chk(g2[ch], reg_m[ch][4:0]);
    chk(x2[ch], s2[reg_m[ch][4:0]]);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic eh);
    logic [7:0] d;
    logic       h;
    core.rd(a, d, h);
    chk(d, e);
    chk(h, eh);
  endtask

  task automatic both_ok();
    chk_gain(0);
    chk_gain(1);
    rdchk(SGS_ADDR_CH1, reg_m[0], 1'b1);
    rdchk(SGS_ADDR_CH2, reg_m[1], 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    mismatches++;
    conclude();
  end

  initial begin
    logic [31:0] r;
    logic [7:0]  d8;
    logic        h1;
    rst_n = 1'b0;
    ce = 1'b1;
    reg_m = '{8'h00, 8'h00};
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    both_ok();
    // every code of channel one, random codes on channel two
    for (int k = 0; k < 256; k++) begin
      r = xs();
      reg_m[0] = k[7:0];
      reg_m[1] = r[7:0];
      core.wr(SGS_ADDR_CH1, reg_m[0]);
      core.wr(SGS_ADDR_CH2, reg_m[1]);
      @(negedge clk_sys);
      both_ok();
    end
    // write and read back on consecutive edges
    r = xs();
    reg_m[0] = r[15:8];
    core.wr_rd(SGS_ADDR_CH1, reg_m[0], d8, h1);
    chk(d8, reg_m[0]);
    chk(h1, 1'b1);
    @(negedge clk_sys);
    both_ok();
    // unmapped neighbours neither store nor answer
    core.wr(8'hA3, ~reg_m[0]);
    core.wr(8'hA0, ~reg_m[1]);
    rdchk(8'hA0, 8'h00, 1'b0);
    rdchk(8'hA3, 8'h00, 1'b0);
    both_ok();
    // frozen while the enable is low
    ce = 1'b0;
    core.wr(SGS_ADDR_CH1, ~reg_m[0]);
    ce = 1'b1;
    both_ok();
    // second reset in mid-run clears both registers
    rst_n = 1'b0;
    reg_m = '{8'h00, 8'h00};
    @(negedge clk_sys);
    chk_gain(0);
    chk_gain(1);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    both_ok();
    conclude();
  end
endmodule // sensor_gain_select_regs_bench

`default_nettype wire
